// File: cirl_defs.vh
// Constants for the core interrupt request logic
`ifndef CIRL_DEFS_VH
`define CIRL_DEFS_VH
// ----------------------------------------
// Register word offsets
// ----------------------------------------
`define CIRL_OFS_STATUS   4'h0
`define CIRL_OFS_MASK     4'h1
`define CIRL_OFS_ENABLE   4'h2
`define CIRL_OFS_PENDING  4'h3
`define CIRL_OFS_CTRL     4'h4
`define CIRL_OFS_VECTOR   4'h5
`define CIRL_OFS_ACK      4'h6
`define CIRL_OFS_SOFTCMD  4'h7
// ----------------------------------------
// Sources and widths
// ----------------------------------------
`define CIRL_NSRC         4'h8
`define CIRL_SRC_W        8
`define CIRL_LINE_W       6
`define CIRL_VEC_W        8
// Source indices, in priority order
`define CIRL_S_PROT_A     3'h0
`define CIRL_S_PROT_B     3'h1
`define CIRL_S_ADC        3'h2
`define CIRL_S_EXT_A      3'h3
`define CIRL_S_EXT_B      3'h4
`define CIRL_S_SPI        3'h5
`define CIRL_S_SCI        3'h6
`define CIRL_S_CAN        3'h7
// ----------------------------------------
// Vectors
// ----------------------------------------
`define CIRL_VEC_RESET    8'h00
`define CIRL_VEC_NMI      8'h24
`define CIRL_VEC_TRAP     8'h22
`define CIRL_VEC_EMU      8'h26
`define CIRL_VEC_NONE     8'h00
// Peripheral vectors per source
`define CIRL_PIV_PROT_A   8'h20
`define CIRL_PIV_PROT_B   8'h19
`define CIRL_PIV_ADC      8'h04
`define CIRL_PIV_EXT_A    8'h01
`define CIRL_PIV_EXT_B    8'h11
`define CIRL_PIV_SPI      8'h05
`define CIRL_PIV_SCI      8'h06
`define CIRL_PIV_CAN      8'h40
// ----------------------------------------
// Soft command codes, bits [9:8] of the soft command word
// ----------------------------------------
`define CIRL_CMD_SOFT_IRQ_INSTRUCTION     2'h1
`define CIRL_CMD_NMI      2'h2
`define CIRL_CMD_TRAP     2'h3
// ----------------------------------------
// Control bits and status layout
// ----------------------------------------
`define CIRL_CTRL_GMASK   0
`define CIRL_CTRL_EMU     1
`define CIRL_EV_SOFT      0
`define CIRL_EV_RESET     1
`define CIRL_EV_WDOG      2
`define CIRL_EV_HW        3
`define CIRL_EV_W         4
`define CIRL_RST_MASK     6'h00
`define CIRL_RST_ENABLE   8'h00
`endif

// File: cirl_line_map.v
// Source to core line and peripheral vector lookup
`timescale 1ns/1ps
`include "cirl_defs.vh"
module cirl_line_map
(
   input  wire                      clk,
   input  wire                      sys_rst,
   input  wire [`CIRL_SRC_W-1:0]    srcReq,
   output reg  [`CIRL_LINE_W-1:0]   lineReq,
   output reg  [`CIRL_VEC_W-1:0]    topVec,
   output reg  [2:0]                topIdx,
   output reg                       topValid
);
   integer i;
   reg [`CIRL_LINE_W-1:0] next_lineReq;
   reg [`CIRL_VEC_W-1:0]  next_topVec;
   reg [2:0]              next_topIdx;
   reg                    next_topValid;
   // ----------------------------------------
   // Lookup tables
   // ----------------------------------------
   // Core line that a source shares (protection B on line 1, all others on line 0)
   function [2:0] lineOf;
      input [2:0] s;
      begin
         case (s)
            `CIRL_S_PROT_A: lineOf = 3'h0;
            `CIRL_S_PROT_B: lineOf = 3'h1;
            `CIRL_S_ADC:    lineOf = 3'h0;
            `CIRL_S_EXT_A:  lineOf = 3'h0;
            `CIRL_S_EXT_B:  lineOf = 3'h0;
            `CIRL_S_SPI:    lineOf = 3'h0;
            `CIRL_S_SCI:    lineOf = 3'h0;
            default:        lineOf = 3'h0;
         endcase
      end
   endfunction
   // Unique vector per source
   function [`CIRL_VEC_W-1:0] vecOf;
      input [2:0] s;
      begin
         case (s)
            `CIRL_S_PROT_A: vecOf = `CIRL_PIV_PROT_A;
            `CIRL_S_PROT_B: vecOf = `CIRL_PIV_PROT_B;
            `CIRL_S_ADC:    vecOf = `CIRL_PIV_ADC;
            `CIRL_S_EXT_A:  vecOf = `CIRL_PIV_EXT_A;
            `CIRL_S_EXT_B:  vecOf = `CIRL_PIV_EXT_B;
            `CIRL_S_SPI:    vecOf = `CIRL_PIV_SPI;
            `CIRL_S_SCI:    vecOf = `CIRL_PIV_SCI;
            default:        vecOf = `CIRL_PIV_CAN;
         endcase
      end
   endfunction
   // ----------------------------------------
   // Grouping onto shared lines, highest priority first
   // ----------------------------------------
   always @*
   begin
      next_lineReq  = {`CIRL_LINE_W{1'b0}};
      next_topVec   = `CIRL_VEC_NONE;
      next_topIdx   = 3'h0;
      next_topValid = 1'b0;
      // Walk downward so the lowest index wins
      for (i = `CIRL_SRC_W - 1; i >= 0; i = i - 1)
      begin
         if (srcReq[i])
         begin
            next_lineReq[lineOf(i[2:0])] = 1'b1; // R13
            next_topVec   = vecOf(i[2:0]);        // R14
            next_topIdx   = i[2:0];
            next_topValid = 1'b1;
         end
      end
   end
   // Registered lookup result
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         lineReq  <= {`CIRL_LINE_W{1'b0}};
         topVec   <= `CIRL_VEC_NONE;
         topIdx   <= 3'h0;
         topValid <= 1'b0;
      end
      else
      begin
         lineReq  <= next_lineReq;
         topVec   <= next_topVec;
         topIdx   <= next_topIdx;
         topValid <= next_topValid;
      end
   end
endmodule // cirl_line_map

// File: cirl_core_irq.v
// Core interrupt and reset request logic with Avalon-MM registers
// Contract
// R1: Reset served first, no arbitration
// R2: Maskables disabled after reset until enabled
// R3: Reset sources: pin and watchdog only
// R4: Four external pins: two general, two protection
// R5: External irq needs enable and line mask
// R6: Peripherals gated by enable and line mask
// R7: Soft interrupt branches to operand, sets mask
// R8: Nonmaskable instruction branches 24h, sets mask
// R9: No hardware nonmaskable input exists
// R10: Trap branches to 22h
// R11: Trap leaves global mask unchanged
// R12: Emulator trap via soft or trap
// R13: Peripherals share six core lines; the line map uses only line 1 (protection B) and line 0 (all other sources)
// R14: Each shared source has unique vector
// R15: Reset priority one, vector 0000h
// R16: Protection A bit 0, vector 0020h
// R17: Requests stay pending until acknowledged
`timescale 1ns/1ps
`include "cirl_defs.vh"
module cirl_core_irq
(
   input  wire          clk,
   input  wire          sys_rst,
   // Avalon-MM slave
   input  wire [3:0]    avs_address,
   input  wire          avs_read,
   input  wire          avs_write,
   input  wire [31:0]   avs_writedata,
   output reg  [31:0]   avs_readdata,
   output reg           avs_waitrequest,
   // Reset sources
   input  wire          resetPin,
   input  wire          wdogTimeout,
   // External pins
   input  wire          extIrqPinA,
   input  wire          extIrqPinB,
   input  wire          powerProtectIrqA,
   input  wire          powerProtectIrqB,
   // Peripheral requests
   input  wire          adcIrq,
   input  wire          spiIrq,
   input  wire          sciIrq,
   input  wire          canIrq,
   // Core side
   output reg           coreReset,
   output reg  [5:0]    coreLines,
   output reg           branchValid,
   output reg  [7:0]    branchVector,
   output reg           globalMaskBit,
   output reg           irqOut
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   reg [`CIRL_SRC_W-1:0]  pending;      // Latched requests
   reg [`CIRL_SRC_W-1:0]  enable;       // Per-source enables
   reg [`CIRL_LINE_W-1:0] lineMask;     // Core line mask
   reg [`CIRL_EV_W-1:0]   status;       // Sticky event bits
   reg [`CIRL_EV_W-1:0]   evMask;       // Event mask
   reg                    emuTrapSel;   // Emulator trap routing
   reg                    rstDone;      // Reset-service in progress flag
   reg                    ackStrobe;    // Acknowledge of top source
   reg [7:0]              ackBits;      // Explicit acknowledges
   wire [`CIRL_SRC_W-1:0] rawReq;
   wire [`CIRL_SRC_W-1:0] gatedReq;
   wire [`CIRL_LINE_W-1:0] lineReq;
   wire [`CIRL_VEC_W-1:0] topVec;
   wire [2:0]             topIdx;
   wire                   topValid;
   wire                   anyReset;
   wire                   busGo;
   wire                   wrHit;
   wire [1:0]             cmdCode;
   wire [`CIRL_EV_W-1:0]  evSet;
   reg  [`CIRL_SRC_W-1:0] next_pending;
   reg  [31:0]            next_readdata;

   // Only pin and watchdog request reset; no hardware NMI input exists
   assign anyReset = resetPin | wdogTimeout; // R3 R9

   // External and peripheral requests, protection A at bit 0
   assign rawReq = {canIrq, sciIrq, spiIrq, extIrqPinB, extIrqPinA, adcIrq,
                    powerProtectIrqB, powerProtectIrqA}; // R4 R16

   // Enable gating per source; line mask gating comes later on each source's core line
   assign gatedReq = pending & enable; // R5 R6

   // Bus handshake: one wait cycle, request answered on second edge
   assign busGo   = (avs_read | avs_write) & avs_waitrequest;
   assign wrHit   = avs_write & ~avs_waitrequest;
   assign cmdCode = avs_writedata[9:8];

   // ----------------------------------------
   // Grouping and vector lookup
   // ----------------------------------------
   cirl_line_map u_map
   (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .srcReq   (gatedReq),
      .lineReq  (lineReq),
      .topVec   (topVec),
      .topIdx   (topIdx),
      .topValid (topValid)
   );

   // ----------------------------------------
   // Avalon-MM handshake
   // ----------------------------------------
   // Waitrequest drops for exactly one cycle per request
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         avs_waitrequest <= 1'b1;
      else if (busGo)
         avs_waitrequest <= 1'b0;
      else
         avs_waitrequest <= 1'b1;
   end

   // ----------------------------------------
   // Pending latch
   // ----------------------------------------
   // Set wins over acknowledge, so a new edge is never lost
   always @*
   begin
      next_pending = pending;
      if (ackStrobe)
         next_pending[topIdx] = 1'b0;
      next_pending = (next_pending & ~ackBits) | rawReq; // R17
   end

   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         pending <= {`CIRL_SRC_W{1'b0}};
      else if (anyReset)
         pending <= {`CIRL_SRC_W{1'b0}}; // R1
      else
         pending <= next_pending;
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         enable     <= `CIRL_RST_ENABLE;
         lineMask   <= `CIRL_RST_MASK;
         evMask     <= {`CIRL_EV_W{1'b0}};
         emuTrapSel <= 1'b0;
         ackBits    <= 8'h00;
      end
      else if (anyReset)
      begin
         // Reset pin or watchdog clears everything at once
         enable     <= `CIRL_RST_ENABLE; // R1 R2
         lineMask   <= `CIRL_RST_MASK;   // R2
         evMask     <= {`CIRL_EV_W{1'b0}};
         emuTrapSel <= 1'b0;
         ackBits    <= 8'h00;
      end
      else
      begin
         ackBits <= 8'h00;
         if (wrHit)
         begin
            case (avs_address)
               `CIRL_OFS_MASK:    evMask     <= avs_writedata[`CIRL_EV_W-1:0];
               `CIRL_OFS_ENABLE:  enable     <= avs_writedata[`CIRL_SRC_W-1:0];
               `CIRL_OFS_CTRL:    lineMask   <= avs_writedata[`CIRL_LINE_W-1:0];
               `CIRL_OFS_ACK:     ackBits    <= avs_writedata[`CIRL_SRC_W-1:0];
               `CIRL_OFS_VECTOR:  emuTrapSel <= avs_writedata[`CIRL_CTRL_EMU];
               default:           ackBits    <= 8'h00;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Global mask bit and branch requests
   // ----------------------------------------
   // Software writes the global mask via the soft command register bit 0
   // Hardware branch takes one line of lineReq & lineMask
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         globalMaskBit <= 1'b1;                   // R2
         branchValid   <= 1'b0;
         branchVector  <= `CIRL_VEC_RESET;
         coreReset     <= 1'b1;
         rstDone       <= 1'b1;
         ackStrobe     <= 1'b0;
      end
      else if (anyReset)
      begin
         // Reset preempts everything, vector 0000h
         coreReset     <= 1'b1;                   // R1 R15
         globalMaskBit <= 1'b1;                   // R2
         branchValid   <= 1'b1;
         branchVector  <= `CIRL_VEC_RESET;        // R15
         rstDone       <= 1'b1;
         ackStrobe     <= 1'b0;
      end
      else
      begin
         coreReset   <= 1'b0;
         branchValid <= 1'b0;
         ackStrobe   <= 1'b0;
         if (wrHit && avs_address == `CIRL_OFS_SOFTCMD)
         begin
            case (cmdCode)
               `CIRL_CMD_SOFT_IRQ_INSTRUCTION:
               begin
                  branchValid   <= 1'b1;
                  branchVector  <= avs_writedata[7:0];  // R7
                  globalMaskBit <= 1'b1;                // R7
               end
               `CIRL_CMD_NMI:
               begin
                  branchValid   <= 1'b1;
                  branchVector  <= `CIRL_VEC_NMI;       // R8
                  globalMaskBit <= 1'b1;                // R8
               end
               `CIRL_CMD_TRAP:
               begin
                  // Trap keeps the global mask as it is
                  branchValid  <= 1'b1;
                  branchVector <= emuTrapSel ? `CIRL_VEC_EMU
                                             : `CIRL_VEC_TRAP; // R10 R11 R12
               end
               default:
               begin
                  // Code zero writes the global mask bit and clears rstDone when bit 0 is low
                  globalMaskBit <= avs_writedata[`CIRL_CTRL_GMASK];
                  rstDone       <= rstDone & avs_writedata[`CIRL_CTRL_GMASK];
               end
            endcase
            if (cmdCode == `CIRL_CMD_SOFT_IRQ_INSTRUCTION && emuTrapSel)
               branchVector <= `CIRL_VEC_EMU;           // R12
         end
         else if (topValid && !globalMaskBit
                  && |(lineReq & lineMask))
         begin
            // Maskable branch only when global and line mask allow
            branchValid   <= 1'b1;
            branchVector  <= topVec;                  // R5 R6 R14
            globalMaskBit <= 1'b1;
            ackStrobe     <= 1'b1;                    // R17
         end
      end
   end

   // ----------------------------------------
   // Core line outputs
   // ----------------------------------------
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         coreLines <= {`CIRL_LINE_W{1'b0}};
      else
         coreLines <= lineReq & lineMask; // R5 R6 R13
   end

   // ----------------------------------------
   // Sticky events and interrupt output
   // ----------------------------------------
   assign evSet = {topValid, wdogTimeout, resetPin,
                   wrHit && avs_address == `CIRL_OFS_SOFTCMD && cmdCode != 2'h0};

   // Read of status clears it, but a same-cycle event survives
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         status <= {`CIRL_EV_W{1'b0}};
      else if (avs_read && !avs_waitrequest && avs_address == `CIRL_OFS_STATUS)
         status <= evSet;
      else
         status <= status | evSet;
   end

   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         irqOut <= 1'b0;
      else
         irqOut <= |(status & evMask);
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always @*
   begin
      next_readdata = 32'h0000_0000;
      case (avs_address)
         `CIRL_OFS_STATUS:  next_readdata[`CIRL_EV_W-1:0]   = status;
         `CIRL_OFS_MASK:    next_readdata[`CIRL_EV_W-1:0]   = evMask;
         `CIRL_OFS_ENABLE:  next_readdata[`CIRL_SRC_W-1:0]  = enable;
         `CIRL_OFS_PENDING: next_readdata[`CIRL_SRC_W-1:0]  = pending;
         `CIRL_OFS_CTRL:    next_readdata[`CIRL_LINE_W-1:0] = lineMask;
         `CIRL_OFS_VECTOR:  next_readdata[`CIRL_CTRL_EMU]   = emuTrapSel;
         `CIRL_OFS_SOFTCMD:
            next_readdata[1:0] = {rstDone, globalMaskBit};
         default:           next_readdata = 32'h0000_0000;
      endcase
   end

   // Read data registered on the wait cycle, valid at release edge
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         avs_readdata <= 32'h0000_0000;
      else if (busGo && avs_read)
         avs_readdata <= next_readdata;
   end
endmodule // cirl_core_irq

// File: cirl_core_irq_properties.sv
// Concurrent checks on the core interrupt request logic ports
`timescale 1ns/1ps
`include "cirl_defs.vh"
module cirl_core_irq_properties
(
   input wire          clk,
   input wire          sys_rst,
   input wire [3:0]    avs_address,
   input wire          avs_read,
   input wire          avs_write,
   input wire [31:0]   avs_writedata,
   input wire [31:0]   avs_readdata,
   input wire          avs_waitrequest,
   input wire          resetPin,
   input wire          wdogTimeout,
   input wire          coreReset,
   input wire [5:0]    coreLines,
   input wire          branchValid,
   input wire [7:0]    branchVector,
   input wire          globalMaskBit
);
   // ----------------------------------------
   // Helper logic
   // ----------------------------------------
   wire       rstReq = resetPin || wdogTimeout;     // Internal reset request
   wire       wrAcc  = avs_write && !avs_waitrequest; // Write taking effect
   // Soft command accepted, ignored when a reset request races it
   wire       cmdAcc = wrAcc && (avs_address == 4'h7) && !rstReq;
   wire [1:0] cmd    = avs_writedata[9:8];           // Command code field
   reg        emuRoute;                              // Shadow of the routing bit
   // Shadow the emulator routing bit; pin or watchdog reset clears it first
   always @(posedge clk or posedge sys_rst)
      if (sys_rst)
         emuRoute <= 1'b0;
      else if (rstReq)
         emuRoute <= 1'b0;
      else if (wrAcc && avs_address == 4'h5)
         emuRoute <= avs_writedata[1];
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   reset_entry_a:
      assert property (rstReq |=> coreReset && branchValid
         && branchVector == `CIRL_VEC_RESET) else $error("Reset entry missing");
   reset_mask_a:
      assert property (rstReq |=> globalMaskBit [*2]) else $error("Mask open after reset");
   bus_answer_a:
      assert property ((avs_read || avs_write) && avs_waitrequest && !rstReq
         |=> !avs_waitrequest) else $error("Bus request not answered");
   bus_pulse_a:
      assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
         else $error("Answer longer than one cycle");
   unmapped_read_a:
      assert property (avs_read && !avs_waitrequest && avs_address[3]
         |-> avs_readdata == 32'h0) else $error("Unmapped read not zero");
   nmi_branch_a:
      assert property (cmdAcc && cmd == `CIRL_CMD_NMI |=> branchValid
         && branchVector == `CIRL_VEC_NMI && globalMaskBit) else $error("Bad nmi branch");
   trap_branch_a:
      assert property (cmdAcc && cmd == `CIRL_CMD_TRAP |=> branchValid && $stable(globalMaskBit)
         && branchVector == (emuRoute ? `CIRL_VEC_EMU : `CIRL_VEC_TRAP))
         else $error("Bad trap branch");
   soft_branch_a:
      assert property (cmdAcc && cmd == `CIRL_CMD_SOFT_IRQ_INSTRUCTION |=> branchValid && globalMaskBit
         && branchVector == (emuRoute ? `CIRL_VEC_EMU : $past(avs_writedata[7:0])))
         else $error("Bad soft branch");
   hw_take_a:
      assert property (coreLines != 6'h00 && !globalMaskBit && !avs_write && !branchValid
         && !rstReq |-> ##[1:2] (branchValid && globalMaskBit))
         else $error("Allowed line not taken");
endmodule // cirl_core_irq_properties
bind cirl_core_irq cirl_core_irq_properties u_props (.clk(clk), .sys_rst(sys_rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .resetPin(resetPin), .wdogTimeout(wdogTimeout),
   .coreReset(coreReset), .coreLines(coreLines), .branchValid(branchValid),
   .branchVector(branchVector), .globalMaskBit(globalMaskBit));

// File: cirl_core_model.sv
// Behavioural processor core that takes the branches handed to it
`timescale 1ns/1ps
module cirl_core_model
(
   input  wire          clk,
   input  wire          sys_rst,
   input  wire          branchValid,
   input  wire [7:0]    branchVector,
   output reg  [7:0]    lastVector,
   output reg  [15:0]   branchCount
);
   // Count every branch; a vector of zero is the reset entry
   always @(posedge clk or posedge sys_rst)
      if (sys_rst)
      begin
         lastVector  <= 8'h00;
         branchCount <= 16'h0000;
      end
      else if (branchValid)
      begin
         lastVector  <= branchVector;
         branchCount <= branchCount + 16'h0001;
      end
endmodule // cirl_core_model

// File: tb_top.sv
// Self-checking testbench for the core interrupt request logic
`timescale 1ns/1ps
`include "cirl_defs.vh"
module tb_top;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   reg          clk;             // 25 MHz clock
   reg          sys_rst;         // Async reset
   reg  [3:0]   avs_address;     // Word index
   reg          avs_read;        // Read strobe
   reg          avs_write;       // Write strobe
   reg  [31:0]  avs_writedata;   // Write data
   wire [31:0]  avs_readdata;    // Read data
   wire         avs_waitrequest; // Slave stall
   reg          resetPin;        // Pin reset source
   reg          wdogTimeout;     // Watchdog reset source
   reg  [7:0]   srcDrive;        // Sources in priority index order
   wire         coreReset;
   wire [5:0]   coreLines;
   wire         branchValid;
   wire [7:0]   branchVector;
   wire         globalMaskBit;
   wire         irqOut;
   wire [7:0]   lastVector;      // Last branch the core took
   wire [15:0]  branchCount;     // Branches the core took
   integer      failCount;
   integer      totalChecks;
   integer      i;
   reg  [31:0]  rd;              // Last read data
   reg  [15:0]  cnt;             // Expected branch count
   reg  [7:0]   pivTable [0:7];  // Expected vector per source
   cirl_core_irq DUT (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .resetPin(resetPin), .wdogTimeout(wdogTimeout), .extIrqPinA(srcDrive[3]),
      .extIrqPinB(srcDrive[4]), .powerProtectIrqA(srcDrive[0]),
      .powerProtectIrqB(srcDrive[1]), .adcIrq(srcDrive[2]), .spiIrq(srcDrive[5]),
      .sciIrq(srcDrive[6]), .canIrq(srcDrive[7]), .coreReset(coreReset),
      .coreLines(coreLines), .branchValid(branchValid), .branchVector(branchVector),
      .globalMaskBit(globalMaskBit), .irqOut(irqOut));
   cirl_core_model u_core (.clk(clk), .sys_rst(sys_rst), .branchValid(branchValid),
      .branchVector(branchVector), .lastVector(lastVector), .branchCount(branchCount));
   // Free-running clock
   always #20 clk = ~clk;
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         totalChecks = totalChecks + 1;
         if (seen !== exp)
         begin
            failCount = failCount + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // One bus cycle; holds the request until waitrequest is sampled low
   task busOp(input wr, input [3:0] a, input [31:0] d);
      begin
         @(posedge clk);
         avs_address   <= a;
         avs_writedata <= d;
         avs_write     <= wr;
         avs_read      <= !wr;
         @(posedge clk);
         while (avs_waitrequest !== 1'b0)
            @(posedge clk);
         rd = avs_readdata;
         avs_write <= 1'b0;
         avs_read  <= 1'b0;
      end
   endtask
   // Let registered outputs land before looking at them
   task settle;
      begin
         repeat (6) @(posedge clk);
         #1;
      end
   endtask
   // Exactly one new branch, to the given vector, with the given mask
   task expBranch(input [7:0] v, input gm);
      begin
         settle;
         chk("branch count", branchCount, cnt + 16'h0001);
         chk("branch vector", lastVector, v);
         chk("global mask", globalMaskBit, gm);
         cnt = branchCount;
      end
   endtask
   // One-cycle request from source index s
   task pulse(input integer s);
      begin
         @(posedge clk);
         srcDrive <= 8'h01 << s;
         @(posedge clk);
         srcDrive <= 8'h00;
      end
   endtask
   task finalReport;
      begin
         if (failCount == 0 && totalChecks > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   // Hang guard, far beyond the expected run of about three hundred cycles
   initial
   begin
      #800000;
      failCount = failCount + 1;
      finalReport;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      clk = 1'b0; sys_rst = 1'b1; avs_address = 4'h0; avs_read = 1'b0; avs_write = 1'b0;
      avs_writedata = 32'h0; resetPin = 1'b0; wdogTimeout = 1'b0; srcDrive = 8'h00;
      failCount = 0; totalChecks = 0;
      pivTable[0] = `CIRL_PIV_PROT_A; pivTable[1] = `CIRL_PIV_PROT_B;
      pivTable[2] = `CIRL_PIV_ADC; pivTable[3] = `CIRL_PIV_EXT_A;
      pivTable[4] = `CIRL_PIV_EXT_B; pivTable[5] = `CIRL_PIV_SPI;
      pivTable[6] = `CIRL_PIV_SCI; pivTable[7] = `CIRL_PIV_CAN;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      settle;
      cnt = branchCount;
      // Defaults, and an unmapped word that still answers
      chk("mask after reset", globalMaskBit, 32'h1);
      busOp(1'b0, 4'h2, 32'h0);
      chk("enable default", rd, 32'h0);
      busOp(1'b0, 4'h4, 32'h0);
      chk("line mask default", rd, 32'h0);
      busOp(1'b0, 4'h9, 32'h0);
      chk("unmapped read", rd, 32'h0);
      // Disabled source stays pending, then line mask gates it
      busOp(1'b1, 4'h7, 32'h0);
      pulse(0);
      settle;
      busOp(1'b0, 4'h3, 32'h0);
      chk("pending held", rd, 32'h1);
      chk("no branch disabled", branchCount, cnt);
      busOp(1'b1, 4'h2, 32'hff);
      settle;
      chk("line blocked", coreLines, 32'h0);
      busOp(1'b1, 4'h4, 32'h3f);
      expBranch(`CIRL_PIV_PROT_A, 1'b1);
      // Every source on its own vector
      for (i = 0; i < 8; i = i + 1)
      begin
         busOp(1'b1, 4'h7, 32'h0);
         pulse(i);
         expBranch(pivTable[i], 1'b1);
      end
      // Acknowledge clears a pending request held off by the mask
      pulse(3);
      settle;
      busOp(1'b0, 4'h3, 32'h0);
      chk("pending masked", rd, 32'h8);
      busOp(1'b1, 4'h6, 32'h8);
      busOp(1'b0, 4'h3, 32'h0);
      chk("pending acked", rd, 32'h0);
      // Soft commands, with the soft event driving the interrupt output
      busOp(1'b1, 4'h1, 32'h1);
      busOp(1'b0, 4'h0, 32'h0);
      busOp(1'b1, 4'h7, 32'h0200);
      expBranch(`CIRL_VEC_NMI, 1'b1);
      chk("irq raised", irqOut, 32'h1);
      busOp(1'b1, 4'h1, 32'h0);
      settle;
      chk("irq masked", irqOut, 32'h0);
      busOp(1'b1, 4'h1, 32'h1);
      settle;
      chk("irq unmasked", irqOut, 32'h1);
      busOp(1'b0, 4'h0, 32'h0);
      settle;
      chk("irq cleared", irqOut, 32'h0);
      busOp(1'b1, 4'h7, 32'h0);
      busOp(1'b1, 4'h7, 32'h0300);
      expBranch(`CIRL_VEC_TRAP, 1'b0);
      busOp(1'b1, 4'h7, 32'h0133);
      expBranch(8'h33, 1'b1);
      busOp(1'b1, 4'h5, 32'h2);
      busOp(1'b1, 4'h7, 32'h0300);
      expBranch(`CIRL_VEC_EMU, 1'b1);
      busOp(1'b1, 4'h7, 32'h0155);
      expBranch(`CIRL_VEC_EMU, 1'b1);
      busOp(1'b1, 4'h5, 32'h0);
      // Both reset sources, cause recorded in status
      for (i = 0; i < 2; i = i + 1)
      begin
         busOp(1'b0, 4'h0, 32'h0);
         @(posedge clk);
         resetPin    <= (i == 0);
         wdogTimeout <= (i == 1);
         @(posedge clk);
         resetPin    <= 1'b0;
         wdogTimeout <= 1'b0;
         expBranch(`CIRL_VEC_RESET, 1'b1);
         busOp(1'b0, 4'h0, 32'h0);
         chk("reset cause", rd & 32'h6, 32'h2 << i);
      end
      // Second reset in mid-run
      busOp(1'b1, 4'h2, 32'hff);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      settle;
      chk("mask after rerun", globalMaskBit, 32'h1);
      busOp(1'b0, 4'h2, 32'h0);
      chk("enable cleared", rd, 32'h0);
      finalReport;
   end
endmodule // tb_top
